//--- rtl/serial_led_shift_latch_driver.sv
// serial-in parallel-out shift, latch and output gating for eight led channels
`timescale 1ns/100ps
`default_nettype none

module serial_led_shift_latch_driver
  import led_shift_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic serial_clk_pin,
  input wire logic serial_data_pin,
  input wire logic latch_strobe_pin,
  input wire logic output_enable_n,
  input wire logic shift_pause,
  output logic shift_ready,
  output logic [NUM_CHANNELS-1:0] channel_outputs,
  output logic cascade_data_output_a,
  output logic cascade_data_output_b
);

  logic [NUM_PINS-1:0] sync1_q;
  logic [NUM_PINS-1:0] sync2_q;
  logic clk_prev_q;
  logic clk_rise;
  logic [BUF_WIDTH-1:0] buf_mem_q [BUF_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic buf_valid;
  logic push;
  logic pop;
  logic [BUF_WIDTH-1:0] head_bit;
  logic [NUM_CHANNELS-1:0] shift_q;
  logic [NUM_CHANNELS-1:0] latch_q;
  logic [NUM_CHANNELS-1:0] channel_q;

  // pins are asynchronous to core_clk; disable pin resets high so channels start off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
    end else begin
      sync1_q <= {output_enable_n, latch_strobe_pin, serial_data_pin, serial_clk_pin};
      sync2_q <= sync1_q;
    end
  end

  // edge found on the second stage so data and clock keep equal delay
  always_ff @(posedge core_clk) begin
    if (rst) begin
      clk_prev_q <= 1'b0;
    end else begin
      clk_prev_q <= sync2_q[PIN_CLK];
    end
  end

  assign clk_rise = sync2_q[PIN_CLK] & ~clk_prev_q;

  // two-entry buffer: a paused consumer loses no sampled bit until two are waiting
  assign buf_valid = (count_q != '0);
  assign shift_ready = (count_q != BUF_FULL_COUNT);
  assign push = clk_rise & shift_ready;
  assign pop = buf_valid & ~shift_pause;
  assign head_bit = buf_mem_q[rd_ptr_q];

  always_ff @(posedge core_clk) begin
    if (rst) begin
      for (int i = 0; i < BUF_DEPTH; i++) begin
        buf_mem_q[i] <= '0;
      end
    end else if (push) begin
      buf_mem_q[wr_ptr_q] <= sync2_q[PIN_DATA];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_ptr_q <= '0;
    end else if (push) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rd_ptr_q <= '0;
    end else if (pop) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // a push and a pop in one cycle leave the count alone
  always_ff @(posedge core_clk) begin
    if (rst) begin
      count_q <= '0;
    end else if (push && !pop) begin
      count_q <= count_q + 1'b1;
    end else if (pop && !push) begin
      count_q <= count_q - 1'b1;
    end
  end

  // newest bit enters stage zero, oldest falls off stage seven
  always_ff @(posedge core_clk) begin
    if (rst) begin
      shift_q <= SHIFT_RESET;
    end else if (pop) begin
      shift_q <= {shift_q[NUM_CHANNELS-2:0], head_bit};
    end
  end

  assign cascade_data_output_a = shift_q[NUM_CHANNELS-1];
  assign cascade_data_output_b = shift_q[NUM_CHANNELS-1];

  // transparency is sampled, so the latch lags the shift register by one cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      latch_q <= LATCH_RESET;
    end else if (sync2_q[PIN_STROBE]) begin
      latch_q <= shift_q;
    end
  end

  // disable wins over the latch; shifting and latching carry on underneath
  always_ff @(posedge core_clk) begin
    if (rst) begin
      channel_q <= CHANNELS_OFF;
    end else if (sync2_q[PIN_OFF]) begin
      channel_q <= CHANNELS_OFF;
    end else begin
      channel_q <= latch_q;
    end
  end

  assign channel_outputs = channel_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  shift_advance_a: assert property (pop |=>
    shift_q[NUM_CHANNELS-1:1] == $past(shift_q[NUM_CHANNELS-2:0]))
    else $error("shift register did not advance on pop");
  shift_hold_a: assert property (!pop |=> $stable(shift_q))
    else $error("shift register changed without a shift");
  newest_bit_a: assert property (pop |=> shift_q[0] == $past(head_bit))
    else $error("newest bit not in stage zero");
  latch_pass_a: assert property (sync2_q[PIN_STROBE] |=> latch_q == $past(shift_q))
    else $error("latch not transparent while strobe high");
  latch_hold_a: assert property (!sync2_q[PIN_STROBE] |=> $stable(latch_q))
    else $error("latch changed while strobe low");
  channels_off_a: assert property (sync2_q[PIN_OFF] |=> channel_outputs == CHANNELS_OFF)
    else $error("channels on while output disabled");
  channels_follow_a: assert property (!sync2_q[PIN_OFF] |=>
    channel_outputs == $past(latch_q))
    else $error("channels do not follow latch");
  bit_polarity_a: assert property (!sync2_q[PIN_OFF] && latch_q[0] |=> channel_outputs[0])
    else $error("latched one did not switch channel on");
  cascade_out_a: assert property (pop |=> cascade_data_output_a == $past(shift_q[NUM_CHANNELS-2])
    && cascade_data_output_b == cascade_data_output_a)
    else $error("cascade outputs wrong");
  cascade_hold_a: assert property (!pop |=> $stable(cascade_data_output_a))
    else $error("cascade output moved without a shift");

  // buffer bookkeeping: a full buffer drops an edge, it never overwrites
  buf_count_a: assert property (count_q <= BUF_FULL_COUNT)
    else $error("buffer count out of range");
  push_valid_a: assert property (push |=> buf_valid)
    else $error("pushed bit not offered to the shift register");
  count_up_a: assert property (push && !pop |=> count_q == $past(count_q) + 2'h1)
    else $error("buffer count did not rise on push");
  count_down_a: assert property (pop && !push |=> count_q == $past(count_q) - 2'h1)
    else $error("buffer count did not fall on pop");
  capture_data_a: assert property (push |=>
    buf_mem_q[$past(wr_ptr_q)] == $past(sync2_q[PIN_DATA]))
    else $error("sampled bit not stored in the buffer");
  fifo_order_a: assert property (push && !buf_valid |=>
    head_bit == $past(sync2_q[PIN_DATA]))
    else $error("bit pushed into empty buffer is not at its head");
  drop_full_a: assert property (clk_rise && !shift_ready && !pop |=> $stable(count_q))
    else $error("edge taken while buffer full");
  ready_return_a: assert property (!shift_ready && pop |=> shift_ready)
    else $error("ready not restored after a drain");
  pause_hold_a: assert property (shift_pause |=> $stable(shift_q))
    else $error("shift register moved while paused");

  off_latch_a: assert property (sync2_q[PIN_OFF] && sync2_q[PIN_STROBE] |=>
    latch_q == $past(shift_q))
    else $error("latch stopped while outputs disabled");
  polarity_zero_a: assert property (!sync2_q[PIN_OFF] && !latch_q[NUM_CHANNELS-1] |=>
    !channel_outputs[NUM_CHANNELS-1])
    else $error("latched zero left channel on");
  // disable low for two samples and strobe low for the earlier one: nothing may reach the channels
  channels_frozen_a: assert property (!sync2_q[PIN_OFF] && !$past(sync2_q[PIN_OFF])
    && !$past(sync2_q[PIN_STROBE]) |=> $stable(channel_outputs))
    else $error("channels changed while latch held");
  transparent_path_a: assert property (sync2_q[PIN_STROBE] && !sync2_q[PIN_OFF]
    ##1 !sync2_q[PIN_OFF] |=> channel_outputs == $past(shift_q, 2))
    else $error("strobed data did not reach the channels");

  // reset is what this one watches, so the default disable is switched off
  reset_clear_a: assert property (disable iff (1'b0) rst |=>
    channel_outputs == CHANNELS_OFF && !cascade_data_output_a && shift_ready)
    else $error("outputs not cleared by reset");

  shift_full_byte_c: cover property (pop [*8]);
  latch_update_c: cover property (pop ##1 sync2_q[PIN_STROBE] ##1 !sync2_q[PIN_STROBE]);
  buf_full_c: cover property (!shift_ready ##1 clk_rise);
  stall_drain_c: cover property (!shift_ready ##1 pop ##1 pop);
  latch_while_off_c: cover property (sync2_q[PIN_OFF] && sync2_q[PIN_STROBE]);

endmodule : serial_led_shift_latch_driver
`default_nettype wire

//--- rtl/led_shift_pkg.sv
// constants shared by the serial led shift/latch driver
package led_shift_pkg;
  localparam int unsigned NUM_CHANNELS = 8;
  localparam int unsigned SYNC_STAGES = 2;
  localparam int unsigned BUF_WIDTH = 1;
  localparam int unsigned BUF_DEPTH = 2;
  localparam int unsigned PTR_W = 1;
  localparam int unsigned CNT_W = 2;
  localparam logic [CNT_W-1:0] BUF_FULL_COUNT = 2'h2;
  localparam int unsigned PIN_CLK = 0;
  localparam int unsigned PIN_DATA = 1;
  localparam int unsigned PIN_STROBE = 2;
  localparam int unsigned PIN_OFF = 3;
  localparam int unsigned NUM_PINS = 4;
  localparam logic [NUM_CHANNELS-1:0] SHIFT_RESET = 8'h00;
  localparam logic [NUM_CHANNELS-1:0] LATCH_RESET = 8'h00;
  localparam logic [NUM_CHANNELS-1:0] CHANNELS_OFF = 8'h00;
  localparam logic [NUM_PINS-1:0] SYNC_RESET = 4'h8;
endpackage : led_shift_pkg

//--- testbench/led_host_model.sv
// host model driving the serial clock and data pins
`timescale 1ns/100ps
`default_nettype none
module led_host_model (
  input wire logic core_clk,
  output logic sclk,
  output logic sdata
);
  initial begin
    sclk = 1'b0;
    sdata = 1'b0;
  end
  // msb first; clock idles low outside frames
  task automatic send(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      @(posedge core_clk) #1 sdata = b[i];
      repeat (2) @(posedge core_clk);
      #1 sclk = 1'b1;
      repeat (4) @(posedge core_clk);
      #1 sclk = 1'b0;
      sdata = ~sdata; // no stale bit once hold is over
    end
  endtask : send
endmodule : led_host_model
`default_nettype wire

//--- testbench/serial_led_shift_latch_driver_tb_top.sv
// testbench for the serial led shift latch driver
`timescale 1ns/100ps
`default_nettype none
module serial_led_shift_latch_driver_tb_top;
  import led_shift_pkg::*;
  logic core_clk = 0, rst = 1, stb = 0, oe_n = 1, pause = 0;
  logic ready, ca, cb, sclk, sdata;
  logic [NUM_CHANNELS-1:0] chan;
  int err_total = 0;
  int checked = 0;
  logic [7:0] rows [4][3] = '{'{8'hA5, 8'h00, 8'hA5}, '{8'h5A, 8'h01, 8'h00},
    '{8'hFF, 8'h00, 8'hFF}, '{8'h01, 8'h00, 8'h01}};
  led_host_model host (.core_clk(core_clk), .sclk(sclk), .sdata(sdata));
  serial_led_shift_latch_driver DUT (.core_clk(core_clk), .rst(rst), .serial_clk_pin(sclk),
    .serial_data_pin(sdata), .latch_strobe_pin(stb), .output_enable_n(oe_n),
    .shift_pause(pause), .shift_ready(ready), .channel_outputs(chan),
    .cascade_data_output_a(ca), .cascade_data_output_b(cb));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string m);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic settle();
    repeat (10) @(posedge core_clk);
    #1;
  endtask : settle
  initial begin
    forever #20 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    err_total++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge core_clk);
    #1 rst = 0;
    check(chan, 8'h00, "reset chan");
    check({6'h00, ready, ca}, 8'h02, "reset ready");
    $display("reset done");
    foreach (rows[i]) begin
      oe_n = rows[i][1][0];
      host.send(rows[i][0]);
      settle();
      stb = 1;
      settle();
      stb = 0;
      settle();
      check(chan, rows[i][2], "row chan");
      check({6'h00, ca, cb}, {6'h00, {2{rows[i][0][7]}}}, "row cascade");
      $display("row %0d done", i);
    end
    host.send(8'h80);
    settle();
    check(chan, 8'h01, "hold");
    oe_n = 1;
    stb = 1;
    settle();
    check(chan, 8'h00, "forced off");
    oe_n = 0;
    host.send(8'h3C);
    settle();
    check(chan, 8'h3C, "transparent");
    stb = 0;
    $display("latch and enable done");
    // buffer keeps two bits while stalled, the rest are dropped
    pause = 1;
    host.send(8'hC0);
    check({7'h00, ready}, 8'h00, "full");
    pause = 0;
    stb = 1;
    settle();
    check(chan, 8'hF3, "stall kept");
    $display("stall done");
    // reset in mid-run with a loaded register and lit channels
    rst = 1;
    settle();
    check(chan, 8'h00, "mid reset chan");
    check({6'h00, ready, ca}, 8'h02, "mid reset ready");
    rst = 0;
    host.send(8'h81);
    settle();
    check(chan, 8'h81, "after reset");
    check({6'h00, ca, cb}, 8'h03, "after reset cascade");
    $display("mid reset done");
    final_report();
  end
endmodule : serial_led_shift_latch_driver_tb_top
`default_nettype wire
